// ### scdc_top.sv
// scdc_top: sync code table, channel word framer and dark calibration faults
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module scdc_top import scdc_pkg::*; (
    // clock, reset and freeze
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // word source
    input  wire logic              in_valid,
    input  wire logic [KIND_W-1:0] in_kind,
    input  wire logic [9:0]        in_data,
    output logic                   in_ready,
    // dark calibration
    input  wire logic              cal_start,
    input  wire logic [CH_N-1:0]   cal_short_pin,
    // channel output
    input  wire logic              out_ready,
    output logic      [9:0]        out_word,
    output logic                   out_valid,
    output logic                   out_idle,
    output logic                   out_win_id
);
    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_DATA = 2'b10
    } scdc_st_t;

    // ==================================================================
    // helpers
    // ==================================================================
    // register class of an address: 0 unmapped, 1 writable, 2 read only
    function automatic logic [1:0] reg_class(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        if (a[1:0] != 2'h0 || a[11:10] != 2'h0) return 2'h0;
        if (i >= IDX_FRAME && i <= IDX_IDLE) return 2'h1;
        if (i >= IDX_FAULT0 && i <= IDX_FAULT3) return 2'h2;
        if (i == IDX_SPARE_A || i == IDX_SPARE_B || i == IDX_CTRL) return 2'h1;
        if (i == IDX_STAT) return 2'h2;
        return 2'h0;
    endfunction

    // sync word: marker bit, start, end, programmable low field
    function automatic logic [9:0] mk_sync(input logic s, input logic e,
                                           input logic [6:0] low);
        return {1'b1, s, e, low};
    endfunction

    // ==================================================================
    // state
    // ==================================================================
    logic [LOW_W-1:0]  frame_low_q;
    logic [CODE_W-1:0] dark_q, valid_q, chk_q, idle_q;
    logic [REG_W-1:0]  spare_a_q, spare_b_q;
    logic              narrow_q, force_idle_q;
    logic [CH_N-1:0]   flt_q, flt_s;
    logic              pready_q, pslverr_q;
    logic [31:0]       prdata_q;
    logic              acc, done, wr;
    logic [7:0]        idx;
    logic [4:0]        level;
    logic              f_valid, f_ready, pop, win_raw;
    logic [12:0]       f_data;
    scdc_st_t          st_q;
    logic [9:0]        hold_q, out_word_q;
    logic              out_valid_q, out_idle_q, out_win_q;
    logic [NARROW_SHIFT:0] win_sh_q;

    assign idx  = paddr[9:2];
    assign acc  = ce && psel && penable && !pready_q;
    assign done = ce && psel && penable && pready_q;
    assign wr   = done && pwrite && (reg_class(paddr) == 2'h1);

    // ==================================================================
    // fault pins
    // ==================================================================
    // fault levels come from the analog calibration side
    scdc_sync2 #(.W(CH_N)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .async_in (cal_short_pin),
        .sync_out (flt_s)
    );

    // sticky flags, cleared when a calibration starts; a set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt_q <= '0;
        end else if (ce) begin
            flt_q <= (flt_q & {CH_N{!cal_start}}) | flt_s;
        end
    end

    // ==================================================================
    // apb slave
    // ==================================================================
    // two-cycle access: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (ce) begin
            pready_q <= psel && penable && !pready_q;
            if (acc) begin
                pslverr_q <= (reg_class(paddr) == 2'h0) ||
                             (pwrite && reg_class(paddr) == 2'h2);
                prdata_q  <= '0;
                case (idx)
                    IDX_FRAME:   prdata_q[LOW_W-1:0]  <= frame_low_q;
                    IDX_DARK:    prdata_q[CODE_W-1:0] <= dark_q;
                    IDX_VALID:   prdata_q[CODE_W-1:0] <= valid_q;
                    IDX_CHKSUM:  prdata_q[CODE_W-1:0] <= chk_q;
                    IDX_IDLE:    prdata_q[CODE_W-1:0] <= idle_q;
                    8'h08:       prdata_q[REG_W-1:0]  <= flt_q[15:0];
                    8'h09:       prdata_q[REG_W-1:0]  <= flt_q[31:16];
                    8'h0a:       prdata_q[REG_W-1:0]  <= flt_q[47:32];
                    IDX_FAULT3:  prdata_q[REG_W-1:0]  <= flt_q[63:48];
                    IDX_SPARE_A: prdata_q[REG_W-1:0]  <= spare_a_q;
                    IDX_SPARE_B: prdata_q[REG_W-1:0]  <= spare_b_q;
                    IDX_CTRL: begin
                        prdata_q[CTRL_NARROW] <= narrow_q;
                        prdata_q[CTRL_IDLE]   <= force_idle_q;
                    end
                    IDX_STAT: begin
                        prdata_q[4:0]       <= level;
                        prdata_q[STAT_IDLE] <= out_idle_q;
                    end
                    default:     prdata_q <= '0;
                endcase
                if (reg_class(paddr) == 2'h0) prdata_q <= '0;
            end
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

    // programmable code table and control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_low_q  <= RST_FRAME;
            dark_q       <= RST_DARK;
            valid_q      <= RST_VALID;
            chk_q        <= RST_CHKSUM;
            idle_q       <= RST_IDLE;
            spare_a_q    <= RST_SPARE_A;
            spare_b_q    <= RST_SPARE_B;
            narrow_q     <= 1'b0;
            force_idle_q <= 1'b0;
        end else if (wr) begin
            case (idx)
                IDX_FRAME:   frame_low_q  <= pwdata[LOW_W-1:0];
                IDX_DARK:    dark_q       <= pwdata[CODE_W-1:0];
                IDX_VALID:   valid_q      <= pwdata[CODE_W-1:0];
                IDX_CHKSUM:  chk_q        <= pwdata[CODE_W-1:0];
                IDX_IDLE:    idle_q       <= pwdata[CODE_W-1:0];
                IDX_SPARE_A: spare_a_q    <= pwdata[REG_W-1:0];
                IDX_SPARE_B: spare_b_q    <= pwdata[REG_W-1:0];
                IDX_CTRL: begin
                    narrow_q     <= pwdata[CTRL_NARROW];
                    force_idle_q <= pwdata[CTRL_IDLE];
                end
                default: ;
            endcase
        end
    end

    // ==================================================================
    // data path
    // ==================================================================
    // source words wait here while the channel is busy or stalled
    scdc_fifo #(.W(13), .D(FIFO_DEPTH)) u_fifo (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .wr_valid (in_valid),
        .wr_data  ({in_kind, in_data}),
        .wr_ready (in_ready),
        .rd_valid (f_valid),
        .rd_data  (f_data),
        .rd_ready (f_ready),
        .level    (level)
    );

    assign f_ready = out_ready && (st_q == ST_RUN) && !force_idle_q;
    assign pop     = ce && f_ready && f_valid;
    assign win_raw = pop && (f_data[12:10] == KIND_START);

    // framer: sync words go out alone, tagged words as tag then data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q        <= ST_RUN;
            hold_q      <= '0;
            out_word_q  <= RST_IDLE;
            out_valid_q <= 1'b0;
            out_idle_q  <= 1'b1;
        end else if (ce) begin
            out_valid_q <= out_ready;
            case (st_q)
                ST_RUN: begin
                    if (out_ready) begin
                        out_idle_q <= !pop;
                        hold_q     <= f_data[9:0];
                        if (!pop) begin
                            out_word_q <= idle_q;
                        end else begin
                            case (f_data[12:10])
                                KIND_START: out_word_q <= mk_sync(1'b1, 1'b0, frame_low_q);
                                KIND_END:   out_word_q <= mk_sync(1'b0, 1'b1, frame_low_q);
                                KIND_DARK: begin
                                    out_word_q <= dark_q;
                                    st_q       <= ST_DATA;
                                end
                                KIND_CRC: begin
                                    out_word_q <= chk_q;
                                    st_q       <= ST_DATA;
                                end
                                KIND_PIXEL: begin
                                    out_word_q <= valid_q;
                                    st_q       <= ST_DATA;
                                end
                                default:    out_word_q <= idle_q;
                            endcase
                        end
                    end
                end
                ST_DATA: begin
                    if (out_ready) begin
                        out_word_q <= hold_q;
                        out_idle_q <= 1'b0;
                        st_q       <= ST_RUN;
                    end
                end
                default: st_q <= ST_RUN;
            endcase
        end
    end

    // window indication, delayed further in narrow mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_sh_q  <= '0;
            out_win_q <= 1'b0;
        end else if (ce) begin
            win_sh_q  <= {win_sh_q[NARROW_SHIFT-1:0], win_raw};
            out_win_q <= narrow_q ? win_sh_q[NARROW_SHIFT] : win_sh_q[0];
        end
    end

    assign out_word   = out_word_q;
    assign out_valid  = out_valid_q;
    assign out_idle   = out_idle_q;
    assign out_win_id = out_win_q;

    // ==================================================================
    // assertions
    // ==================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_win_wide;
        (ce && win_raw) ##1 (ce && !narrow_q);
    endsequence

    sequence s_win_narrow;
        (ce && win_raw) ##1 ce [*4] ##1 (ce && narrow_q);
    endsequence

    a_frame_write: assert property (wr && idx == IDX_FRAME |=>
        frame_low_q == $past(pwdata[6:0]))
        else $error("frame low field not written");

    a_sync_start_word: assert property (ce && out_ready && st_q == ST_RUN && pop
        && f_data[12:10] == KIND_START |=> out_word_q[9:7] == 3'h6 &&
        out_word_q[6:0] == $past(frame_low_q))
        else $error("start sync word malformed");

    a_dark_tag_word: assert property (ce && out_ready && st_q == ST_RUN && pop
        && f_data[12:10] == KIND_DARK |=> out_word_q == $past(dark_q)
        ##1 (!$past(ce) || !$past(out_ready) || out_word_q == $past(hold_q)))
        else $error("dark tag or data wrong");

    a_pixel_tag_word: assert property (ce && out_ready && st_q == ST_RUN && pop
        && f_data[12:10] == KIND_PIXEL |=> out_word_q == $past(valid_q)
        && st_q == ST_DATA)
        else $error("pixel tag wrong");

    a_crc_tag_word: assert property (ce && out_ready && st_q == ST_RUN && pop
        && f_data[12:10] == KIND_CRC |=> out_word_q == $past(chk_q))
        else $error("crc tag wrong");

    a_idle_align_word: assert property (ce && out_ready && st_q == ST_RUN
        && !pop |=> out_word_q == $past(idle_q) && out_idle_q)
        else $error("idle word not sent");

    a_fault_sticky: assert property (ce && !cal_start |=>
        (flt_q & $past(flt_q | flt_s)) == $past(flt_q | flt_s))
        else $error("fault flag lost");

    a_win_wide_delay: assert property (s_win_wide |=> out_win_q)
        else $error("window indication late in wide mode");

    a_win_narrow_delay: assert property (s_win_narrow |=> out_win_q)
        else $error("window indication not shifted by four");

    // an access cycle is answered once, in the following cycle
    a_apb_one_wait: assert property (acc |=> pready_q
        ##1 (!$past(ce) || !pready_q))
        else $error("register answer not one cycle wide");

    // a write to a read-only or unmapped word is refused
    a_apb_refuse: assert property (acc && pwrite && reg_class(paddr) != 2'h1
        |=> pslverr_q)
        else $error("refused write not flagged");

    // a calibration start clears every flag except a fault seen that cycle
    a_fault_clear: assert property (ce && cal_start |=> flt_q == $past(flt_s))
        else $error("fault flags not cleared");

endmodule // scdc_top

// ### scdc_pkg.sv
// scdc_pkg: register map, field layout, reset values and codes of the framer
package scdc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_FRAME   = 8'h03;
    localparam logic [7:0]  IDX_DARK    = 8'h04;
    localparam logic [7:0]  IDX_VALID   = 8'h05;
    localparam logic [7:0]  IDX_CHKSUM  = 8'h06;
    localparam logic [7:0]  IDX_IDLE    = 8'h07;
    localparam logic [7:0]  IDX_FAULT0  = 8'h08;
    localparam logic [7:0]  IDX_FAULT3  = 8'h0b;
    localparam logic [7:0]  IDX_SPARE_A = 8'h0c;
    localparam logic [7:0]  IDX_SPARE_B = 8'h0d;
    localparam logic [7:0]  IDX_CTRL    = 8'h0e;
    localparam logic [7:0]  IDX_STAT    = 8'h0f;
    // field widths and positions
    localparam int unsigned LOW_W       = 7;
    localparam int unsigned CODE_W      = 10;
    localparam int unsigned REG_W       = 16;
    localparam int unsigned CH_N        = 64;
    localparam int unsigned KIND_W      = 3;
    localparam int unsigned CTRL_NARROW = 0;
    localparam int unsigned CTRL_IDLE   = 1;
    localparam int unsigned STAT_IDLE   = 5;
    // reset values
    localparam logic [6:0]  RST_FRAME   = 7'h2a;
    localparam logic [9:0]  RST_DARK    = 10'h015;
    localparam logic [9:0]  RST_VALID   = 10'h035;
    localparam logic [9:0]  RST_CHKSUM  = 10'h059;
    localparam logic [9:0]  RST_IDLE    = 10'h3a6;
    localparam logic [15:0] RST_SPARE_A = 16'h0000;
    localparam logic [15:0] RST_SPARE_B = 16'hffff;
    // timing and sizes
    localparam int unsigned NARROW_SHIFT = 4;
    localparam int unsigned FIFO_DEPTH   = 16;
    // kinds of word offered to the framer
    typedef enum logic [2:0] {
        KIND_PIXEL = 3'h0,
        KIND_DARK  = 3'h1,
        KIND_CRC   = 3'h2,
        KIND_START = 3'h3,
        KIND_END   = 3'h4
    } scdc_kind_t;
endpackage

// ### scdc_sync2.sv
// scdc_sync2: two flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module scdc_sync2 #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // scdc_sync2

// ### scdc_fifo.sv
// scdc_fifo: word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module scdc_fifo #(
    parameter int unsigned W = 13,
    parameter int unsigned D = 16
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // fill side
    input  wire logic         wr_valid,
    input  wire logic [W-1:0] wr_data,
    output logic              wr_ready,
    // drain side
    output logic              rd_valid,
    output logic      [W-1:0] rd_data,
    input  wire logic         rd_ready,
    output logic [$clog2(D):0] level
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign push     = ce && wr_valid && wr_ready;
    assign pop      = ce && rd_valid && rd_ready;
    assign rd_valid = (cnt_q != '0);
    assign rd_data  = mem[rp_q];
    assign level    = cnt_q;

    // occupancy after this cycle
    always_comb begin
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // pointers, count and registered ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q     <= '0;
            rp_q     <= '0;
            cnt_q    <= '0;
            wr_ready <= 1'b1;
        end else if (ce) begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop)  rp_q <= rp_q + 1'b1;
            cnt_q    <= cnt_d;
            wr_ready <= (cnt_d < (AW+1)'(D));
        end
    end

    // storage
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wp_q] <= wr_data;
        end
    end
endmodule // scdc_fifo

// ### scdc_rx_model.sv
// scdc_rx_model: receiver side of the channel, paces slots and decodes sync words
`timescale 1ns/1ps
module scdc_rx_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // pacing
    input  wire logic       stall,
    output logic            out_ready,
    // channel
    input  wire logic [9:0] out_word,
    input  wire logic       out_valid,
    input  wire logic       out_idle,
    // decoded sync words
    output int              starts,
    output int              ends
);
    // =====================================================
    // slot pacing: no slot is offered while stalled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) out_ready <= 1'b0;
        else out_ready <= !stall;
    end
    // sync decode from the fixed upper bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            starts <= 0;
            ends   <= 0;
        end else if (out_valid && !out_idle && out_word[9]) begin
            if (out_word[8:7] == 2'b10) starts <= starts + 1;
            if (out_word[8:7] == 2'b01) ends <= ends + 1;
        end
    end
endmodule // scdc_rx_model

// ### tb.sv
// tb: self-checking bench for the sync code table and channel framer
`timescale 1ns/1ps
module tb import scdc_pkg::*;;
    // =====================================================
    // signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, ce;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic in_valid, in_ready, cal_start, out_ready, out_valid, out_idle, out_win_id;
    logic [2:0]  in_kind;
    logic [9:0]  in_data, out_word;
    logic [63:0] cal_short_pin;
    logic [15:0] rd, fx[4];
    logic        er;
    int mismatches, compares, cyc, t_word, t_win, starts, ends, gw, gn, taken;
    logic [9:0] got[$], exq[$];
    typedef struct packed {
        logic wr; logic [7:0] idx; logic [15:0] wd; logic [15:0] ex; logic we; logic re;
    } scdc_row_t;
    scdc_row_t rows[16] = '{
        '{0, IDX_FRAME, 0, 16'(RST_FRAME), 0, 0}, '{0, IDX_DARK, 0, 16'(RST_DARK), 0, 0},
        '{0, IDX_VALID, 0, 16'(RST_VALID), 0, 0}, '{0, IDX_CHKSUM, 0, 16'(RST_CHKSUM), 0, 0},
        '{0, IDX_IDLE, 0, 16'(RST_IDLE), 0, 0}, '{0, IDX_FAULT0, 0, 16'h0000, 0, 0},
        '{0, IDX_FAULT3, 0, 16'h0000, 0, 0}, '{0, IDX_SPARE_A, 0, RST_SPARE_A, 0, 0},
        '{0, IDX_SPARE_B, 0, RST_SPARE_B, 0, 0}, '{0, 8'h40, 0, 16'h0000, 0, 1},
        '{1, IDX_FRAME, 16'hff55, 16'h0055, 0, 0}, '{1, IDX_DARK, 16'h0123, 16'h0123, 0, 0},
        '{1, IDX_VALID, 16'h00aa, 16'h00aa, 0, 0}, '{1, IDX_CHKSUM, 16'h00c3, 16'h00c3, 0, 0},
        '{1, IDX_IDLE, 16'hfbc7, 16'h03c7, 0, 0}, '{1, IDX_FAULT0, 16'h1234, 16'h0000, 1, 0}};
    // =====================================================
    // design, receiver model, clock
    scdc_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_kind(in_kind), .in_data(in_data),
        .in_ready(in_ready), .cal_start(cal_start), .cal_short_pin(cal_short_pin),
        .out_ready(out_ready), .out_word(out_word), .out_valid(out_valid),
        .out_idle(out_idle), .out_win_id(out_win_id));
    scdc_rx_model rx (.pclk(pclk), .presetn(presetn), .stall(stall), .out_ready(out_ready),
        .out_word(out_word), .out_valid(out_valid), .out_idle(out_idle),
        .starts(starts), .ends(ends));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // channel monitor: data words and window timing
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (out_valid === 1'b1 && out_idle === 1'b0) begin
            got.push_back(out_word);
            t_word <= cyc;
        end
        if (out_win_id === 1'b1) t_win <= cyc;
    end
    // =====================================================
    // tasks
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(16'h0000, 16'h0001);
        rd = prdata[15:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic push(input logic [2:0] k, input logic [9:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        in_kind <= k;
        in_data <= d;
        in_valid <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (in_ready !== 1'b1 && n < 50);
        in_valid <= 1'b0;
    endtask
    task automatic win_gap(output int g);
        push(KIND_START, 10'h000);
        repeat (12) @(posedge pclk);
        g = t_win - t_word;
    endtask
    task automatic print_verdict();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    // =====================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, in_valid, cal_start, stall} = '0;
        ce = 1'b1;
        {paddr, pwdata, in_kind, in_data, cal_short_pin, cyc, t_word, t_win} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        chk(16'(out_word), 16'(RST_IDLE));
        chk(16'(out_idle), 16'h0001);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                apb(1'b1, rows[i].idx, rows[i].wd);
                chk(16'(er), 16'(rows[i].we));
            end
            apb(1'b0, rows[i].idx, 16'h0000);
            chk(rd, rows[i].ex);
            chk(16'(er), 16'(rows[i].re));
        end
        repeat (4) @(posedge pclk);
        chk(16'(out_word), 16'h03c7);
        chk(16'(out_idle), 16'h0001);
        // mixed stream with the programmed codes
        got.delete();
        exq = '{10'h355, 10'h123, 10'h0a5, 10'h0aa, 10'h15a, 10'h0c3, 10'h0f0, 10'h2d5};
        push(KIND_START, 10'h000);
        push(KIND_DARK, 10'h0a5);
        push(KIND_PIXEL, 10'h15a);
        push(KIND_CRC, 10'h0f0);
        push(KIND_END, 10'h000);
        repeat (12) @(posedge pclk);
        chk(16'(got.size()), 16'd8);
        foreach (exq[i]) chk(16'(got[i]), 16'(exq[i]));
        // window indication in both modes
        win_gap(gw);
        apb(1'b1, IDX_CTRL, 16'h0001);
        win_gap(gn);
        chk(16'(gn - gw), 16'(NARROW_SHIFT));
        chk(16'(gw), 16'd1);
        // fifo filled while the receiver stalls, then drained
        stall <= 1'b1;
        repeat (3) @(posedge pclk);
        got.delete();
        in_kind <= KIND_START;
        in_valid <= 1'b1;
        taken = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (in_ready === 1'b1) taken++;
            else break;
        end
        in_valid <= 1'b0;
        stall <= 1'b0;
        chk(16'(taken), 16'(FIFO_DEPTH));
        repeat (60) @(posedge pclk);
        chk(16'(got.size()), 16'(FIFO_DEPTH));
        chk(16'(starts), 16'd19);
        chk(16'(ends), 16'd1);
        // force idle holds a queued word back until released
        apb(1'b1, IDX_CTRL, 16'h0003);
        got.delete();
        push(KIND_END, 10'h000);
        repeat (4) @(posedge pclk);
        apb(1'b0, IDX_STAT, 16'h0000);
        chk(rd, 16'h0021);
        chk(16'(got.size()), 16'd0);
        apb(1'b1, IDX_CTRL, 16'h0001);
        repeat (4) @(posedge pclk);
        chk(16'(got.size()), 16'd1);
        chk(16'(got[0]), 16'h02d5);
        chk(16'(ends), 16'd2);
        // frozen clock enable: a pin pulse in that time leaves no flag
        ce <= 1'b0;
        cal_short_pin <= '1;
        repeat (6) @(posedge pclk);
        cal_short_pin <= '0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, IDX_FAULT3, 16'h0000);
        chk(rd, 16'h0000);
        // dark calibration fault flags, then clear
        fx = '{16'h0001, 16'h0002, 16'h0004, 16'h8000};
        cal_short_pin <= 64'h8000_0004_0002_0001;
        repeat (6) @(posedge pclk);
        cal_short_pin <= '0;
        repeat (6) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, IDX_FAULT0 + 8'(i), 16'h0000);
            chk(rd, fx[i]);
        end
        cal_start <= 1'b1;
        @(posedge pclk);
        cal_start <= 1'b0;
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, IDX_FAULT0 + 8'(i), 16'h0000);
            chk(rd, 16'h0000);
        end
        print_verdict();
    end
endmodule // tb
